/* File: logic/sdac_pkg.sv */
// Package for the serial DAC write-side control block.
// Assumes a core clock of 40 MHz and a separate serial link clock.
package sdac_pkg;

  // Frame variants
  typedef enum logic [1:0] {
    SDAC_RES12,
    SDAC_RES14,
    SDAC_RES16
  } sdac_res_e;

  // Output termination modes, encoded as the two mode bits
  typedef enum logic [1:0] {
    SDAC_NORMAL  = 2'h0,
    SDAC_PD_1K   = 2'h1,
    SDAC_PD_100K = 2'h2,
    SDAC_PD_TRI  = 2'h3
  } sdac_mode_e;

  localparam int unsigned SDAC_SHORT_BITS = 16;
  localparam int unsigned SDAC_LONG_BITS  = 24;
  localparam int unsigned SDAC_DATA_W     = 16;
  localparam int unsigned SDAC_CNT_W      = 5;

  // Field positions in the received word (bit index of first-received = top)
  localparam int unsigned SDAC_SHORT_MODE_LSB = 14;
  localparam int unsigned SDAC_LONG_MODE_LSB  = 16;

  localparam logic [SDAC_CNT_W-1:0] SDAC_SHORT_LAST = 5'h10;
  localparam logic [SDAC_CNT_W-1:0] SDAC_LONG_LAST  = 5'h18;

  localparam logic [SDAC_DATA_W-1:0] SDAC_ZERO_CODE = 16'h0000;
  localparam logic [SDAC_DATA_W-1:0] SDAC_MID_CODE  = 16'h8000;

  // Wake-up settling after leaving power-down
  localparam int unsigned SDAC_CLK_HZ       = 40_000_000;
  localparam int unsigned SDAC_WAKE_NS      = 5000;
  localparam int unsigned SDAC_WAKE_CYCLES  = (SDAC_WAKE_NS * (SDAC_CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned SDAC_WAKE_W       = 8;

  // Decoded command handed from the link domain to the core domain
  typedef struct packed {
    sdac_mode_e             mode;
    logic [SDAC_DATA_W-1:0] code;
  } sdac_cmd_s;

  // Analog control outputs
  typedef struct packed {
    logic bias_on;
    logic amp_on;
    logic ref_on;
    logic string_on;
    logic out_to_amp;
    logic gnd_1k;
    logic gnd_100k;
  } sdac_ana_s;

endpackage

/* File: logic/sdac_write_ctrl.sv */
// Write-side control of a single-channel voltage-output DAC.
// Serial link logic runs on the link clock; the DAC register and mode live on core_clk.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Data sampled on each falling serial clock edge into a 24 bit register, up to the 16th or 24th edge.
// - On the last edge (16th or 24th) the command is captured; it reaches the DAC register three core_clk edges later.
// - Frame select low or high after the last edge: the write stands valid.
// - Short frame: two mode bits first, then 14 data bits, or two ignored bits and 12 data bits.
// - Long frame: six ignored bits, two mode bits, sixteen data bits.
// - Long frame: frame select rising early clears the shifter and discards the frame.
// - Short frame: frame select rising before edge 16 discards the frame.
// - After reset output holds zero or midscale until the first valid write.
// - Mode bits: 00 normal, 01 1k ground, 10 100k ground, 11 three-state.
// - Power-down disconnects the amplifier and ties output to the chosen 1k or 100k load, or leaves it open in three-state.
// - A power-down write still loads its data field into the stored DAC code.
// - Power-down turns off bias, amplifier, reference and resistor string.
// - Leaving power-down waits 5 us before the output is flagged valid.
// - Data field is straight unsigned binary of the resolution's width.
module sdac_write_ctrl
  import sdac_pkg::*;
#(
  parameter sdac_res_e RES      = SDAC_RES16,
  parameter bit        MID_BOOT = 1'b0
) (
  // Core clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Serial link
  input  wire logic                   link_sclk,
  input  wire logic                   frame_sel_n,
  input  wire logic                   serial_din,
  // Converter state
  output logic       [SDAC_DATA_W-1:0] dac_code,
  output sdac_mode_e                   dac_mode,
  output sdac_ana_s                    analog_ctrl,
  output logic                         analog_output_valid,
  output logic                         write_done
);

  localparam bit LONG = (RES == SDAC_RES16);
  localparam logic [SDAC_CNT_W-1:0] LAST = LONG ? SDAC_LONG_LAST : SDAC_SHORT_LAST;
  localparam int unsigned DW = (RES == SDAC_RES16) ? 16 : ((RES == SDAC_RES14) ? 14 : 12);
  localparam logic [SDAC_DATA_W-1:0] BOOT_CODE = MID_BOOT ? SDAC_MID_CODE : SDAC_ZERO_CODE;
  localparam logic [SDAC_WAKE_W-1:0] WAKE_LOAD = SDAC_WAKE_W'(SDAC_WAKE_CYCLES);

  // ---------------- Link domain ----------------
  // Frame select high acts as an asynchronous clear of the shifter and bit count.
  logic                  frame_rst_n;
  logic [23:0]           shift_q;
  logic [SDAC_CNT_W-1:0] bit_cnt_q;
  sdac_cmd_s             cmd_q;
  logic                  cmd_tgl_q;
  logic [23:0]           shift_d;
  sdac_cmd_s             cmd_d;

  assign frame_rst_n = rst_n & ~frame_sel_n;
  assign shift_d     = {shift_q[22:0], serial_din};

  // Decode of the completed word: fields sit relative to the last bit received
  always_comb begin
    cmd_d = '0;
    if (LONG) begin
      cmd_d.mode = sdac_mode_e'(shift_d[SDAC_LONG_MODE_LSB +: 2]);
      cmd_d.code = shift_d[SDAC_DATA_W-1:0];
    end else begin
      cmd_d.mode = sdac_mode_e'(shift_d[SDAC_SHORT_MODE_LSB +: 2]);
      cmd_d.code = SDAC_DATA_W'(shift_d[DW-1:0]);
    end
  end

  // Shift on falling serial clock edges while the frame is open
  always_ff @(negedge link_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_q   <= 24'h000000;
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != LAST) begin
      shift_q   <= shift_d;
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Capture and flag the command on the final edge; extra edges are ignored
  always_ff @(negedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q     <= '0;
      cmd_tgl_q <= 1'b0;
    end else if (!frame_sel_n && bit_cnt_q == LAST - 5'h01) begin
      cmd_q     <= cmd_d;
      cmd_tgl_q <= ~cmd_tgl_q;
    end
  end

  // ---------------- Core domain ----------------
  // The command word is held stable until the next frame completes, so it is
  // safe to read once the synchronised toggle shows a change.
  logic [2:0]             tgl_sync_q;
  logic                   cmd_evt;
  logic [SDAC_DATA_W-1:0] code_q;
  sdac_mode_e             mode_q;
  logic                   written_q;
  logic [SDAC_WAKE_W-1:0] wake_cnt_q;
  logic                   done_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_q <= 3'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], cmd_tgl_q};
    end
  end

  assign cmd_evt = tgl_sync_q[2] ^ tgl_sync_q[1];

  // DAC register and mode update; power-down modes keep the code as written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q    <= BOOT_CODE;
      mode_q    <= SDAC_NORMAL;
      written_q <= 1'b0;
    end else if (cmd_evt) begin
      code_q    <= cmd_q.code;
      mode_q    <= cmd_q.mode;
      written_q <= 1'b1;
    end
  end

  // Wake-up settling when a write returns to normal from power-down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_q <= 8'h00;
    end else if (cmd_evt && mode_q != SDAC_NORMAL && cmd_q.mode == SDAC_NORMAL) begin
      wake_cnt_q <= WAKE_LOAD;
    end else if (cmd_evt && cmd_q.mode != SDAC_NORMAL) begin
      wake_cnt_q <= 8'h00;
    end else if (wake_cnt_q != 8'h00) begin
      wake_cnt_q <= wake_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cmd_evt;
    end
  end

  // Output stage and linear-circuit enables
  always_comb begin
    analog_ctrl = '0;
    case (mode_q)
      SDAC_NORMAL: begin
        analog_ctrl.bias_on    = 1'b1;
        analog_ctrl.amp_on     = 1'b1;
        analog_ctrl.ref_on     = 1'b1;
        analog_ctrl.string_on  = 1'b1;
        analog_ctrl.out_to_amp = 1'b1;
      end
      SDAC_PD_1K:   analog_ctrl.gnd_1k   = 1'b1;
      SDAC_PD_100K: analog_ctrl.gnd_100k = 1'b1;
      SDAC_PD_TRI:  analog_ctrl.gnd_1k   = 1'b0;
      default:      analog_ctrl = '0;
    endcase
  end

  assign dac_code            = code_q;
  assign dac_mode            = mode_q;
  assign analog_output_valid = (mode_q == SDAC_NORMAL) && (wake_cnt_q == 8'h00);
  assign write_done          = done_q;

  // ---------------- Checks ----------------
  sequence leave_pd_s;
    cmd_evt && mode_q != SDAC_NORMAL && cmd_q.mode == SDAC_NORMAL;
  endsequence

  sequence wake_hold_s;
    !analog_output_valid [*8];
  endsequence

  boot_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !written_q |-> code_q == BOOT_CODE)
    else $error("code left boot value without a write");

  update_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_evt |=> code_q == $past(cmd_q.code) && mode_q == $past(cmd_q.mode))
    else $error("command not applied one cycle after event");

  no_spurious_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cmd_evt |=> $stable(code_q) && $stable(mode_q))
    else $error("DAC state changed without a command");

  pd_enables_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q != SDAC_NORMAL |-> !analog_ctrl.amp_on && !analog_ctrl.bias_on
      && !analog_ctrl.ref_on && !analog_ctrl.string_on)
    else $error("linear circuits on during power-down");

  pd_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !analog_ctrl.out_to_amp |-> (analog_ctrl.gnd_1k == (mode_q == SDAC_PD_1K))
      && (analog_ctrl.gnd_100k == (mode_q == SDAC_PD_100K)))
    else $error("wrong power-down termination");

  wake_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    leave_pd_s |=> wake_hold_s ##[1:200] analog_output_valid)
    else $error("wake-up delay wrong");

  done_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_evt |=> write_done ##1 !write_done)
    else $error("write_done not a single pulse");

  frame_clear_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    frame_sel_n |-> bit_cnt_q == 5'h00)
    else $error("bit count not cleared outside a frame");

  count_cap_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    bit_cnt_q <= LAST)
    else $error("bit count exceeded frame length");

  // Helper: counts the cycles the output stays invalid after a return from power-down
  localparam logic [SDAC_WAKE_W-1:0] WAKE_SPAN = SDAC_WAKE_W'(SDAC_WAKE_CYCLES + 1);
  logic [SDAC_WAKE_W-1:0] wake_span_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_span_q <= 8'h00;
    end else if (cmd_evt && mode_q != SDAC_NORMAL && cmd_q.mode == SDAC_NORMAL) begin
      wake_span_q <= 8'h01;
    end else if (mode_q != SDAC_NORMAL || analog_output_valid) begin
      wake_span_q <= 8'h00;
    end else if (wake_span_q != 8'h00 && wake_span_q != 8'hFF) begin
      wake_span_q <= wake_span_q + 8'h01;
    end
  end

  sequence last_edge_s;
    !frame_sel_n && bit_cnt_q == LAST - 5'h01;
  endsequence

  sequence frame_full_s;
    bit_cnt_q == LAST;
  endsequence

  normal_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q == SDAC_NORMAL |-> analog_ctrl.out_to_amp && analog_ctrl.amp_on
      && analog_ctrl.bias_on && analog_ctrl.ref_on && analog_ctrl.string_on)
    else $error("output not driven by amplifier in normal mode");

  normal_noload_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q == SDAC_NORMAL |-> !analog_ctrl.gnd_1k && !analog_ctrl.gnd_100k)
    else $error("ground load active in normal mode");

  tri_open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q == SDAC_PD_TRI |-> !analog_ctrl.gnd_1k && !analog_ctrl.gnd_100k
      && !analog_ctrl.out_to_amp)
    else $error("three-state output not left open");

  amp_detach_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q != SDAC_NORMAL |-> !analog_ctrl.out_to_amp)
    else $error("amplifier still connected in power-down");

  one_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(analog_ctrl.gnd_1k && analog_ctrl.gnd_100k))
    else $error("both ground loads selected");

  pd_code_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q != SDAC_NORMAL && !cmd_evt |=> $stable(code_q))
    else $error("DAC code changed while powered down");

  pd_no_valid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q != SDAC_NORMAL |-> !analog_output_valid)
    else $error("output flagged valid in power-down");

  valid_normal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    analog_output_valid |-> mode_q == SDAC_NORMAL)
    else $error("valid outside normal mode");

  wake_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    leave_pd_s |=> wake_cnt_q == WAKE_LOAD)
    else $error("wake counter not loaded on leaving power-down");

  wake_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wake_cnt_q != 8'h00 && !cmd_evt |=> wake_cnt_q == $past(wake_cnt_q) - 8'h01)
    else $error("wake counter did not step down");

  wake_cancel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_evt && cmd_q.mode != SDAC_NORMAL |=> wake_cnt_q == 8'h00 && !analog_output_valid)
    else $error("power-down write did not cancel wake-up");

  wake_span_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(analog_output_valid) |-> wake_span_q == WAKE_SPAN)
    else $error("wake-up span has the wrong length");

  done_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    write_done |-> $past(cmd_evt))
    else $error("write_done without a command");

  evt_single_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_evt |=> !cmd_evt)
    else $error("one frame seen as two commands");

  written_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    written_q |=> written_q)
    else $error("written flag dropped");

  first_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_evt |=> written_q)
    else $error("written flag not set by a command");

  boot_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !written_q |-> mode_q == SDAC_NORMAL && analog_output_valid)
    else $error("boot state not normal and valid");

  capture_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    last_edge_s |=> cmd_q == $past(cmd_d) && cmd_tgl_q != $past(cmd_tgl_q))
    else $error("command not captured on the final edge");

  no_capture_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    bit_cnt_q != LAST - 5'h01 |=> $stable(cmd_tgl_q))
    else $error("command raised before the final edge");

  hold_full_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    frame_full_s |=> bit_cnt_q == LAST || bit_cnt_q == 5'h00)
    else $error("bit count moved after a full frame");

  hold_data_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    frame_full_s and !frame_sel_n |=> bit_cnt_q == 5'h00 || $stable(shift_q))
    else $error("shifter moved after a full frame");

  shift_step_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    !frame_sel_n && bit_cnt_q < LAST - 5'h01 |=> shift_q[0] == $past(serial_din)
      || bit_cnt_q == 5'h00)
    else $error("serial bit not shifted in");

endmodule

`default_nettype wire

/* File: verif/sdac_host_model.sv */
// Host serial master model that drives the DAC write link.
// Assumes one bench process calls send at a time.
`timescale 1ns/1ps
`default_nettype none
module sdac_host_model (
  // Serial link
  output logic link_sclk,
  output logic frame_sel_n,
  output logic serial_din
);
  initial begin
    link_sclk   = 1'b1;
    frame_sel_n = 1'b1;
    serial_din  = 1'b0;
  end
  // Clock stands still outside frames; data shows the inverse of the last bit after the final clock edge
  task automatic send(input logic [23:0] frame, input int edges, input bit close);
    int i;
    if (frame_sel_n === 1'b0) begin
      frame_sel_n = 1'b1;
      #40;
    end
    frame_sel_n = 1'b0;
    #10;
    for (i = 0; i < edges; i++) begin
      serial_din = (i < 24) ? frame[23 - i] : ~serial_din;
      #7.5 link_sclk = 1'b0;
      #7.5 link_sclk = 1'b1;
    end
    serial_din = ~serial_din;
    #5;
    if (close) begin
      frame_sel_n = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/sdac_write_ctrl_tb.sv */
// Self-checking bench for the serial DAC write control, long-frame variant.
// Assumes the host model drives the link; core inputs change at falling core_clk.
`timescale 1ns/1ps
`default_nettype none
module sdac_write_ctrl_tb;
  import sdac_pkg::*;
  logic                   core_clk;
  logic                   rst_n;
  logic                   link_sclk;
  logic                   frame_sel_n;
  logic                   serial_din;
  logic [SDAC_DATA_W-1:0] dac_code;
  sdac_mode_e             dac_mode;
  sdac_ana_s              analog_ctrl;
  logic                   analog_output_valid;
  logic                   write_done;
  int                     fail_count;
  int                     tests_run;
  int                     done_seen;
  int                     exp_code;
  int                     exp_mode;
  int                     seed;
  int                     k;
  int                     n;
  logic [15:0]            val;

  sdac_write_ctrl #(.RES(SDAC_RES16), .MID_BOOT(1'b0)) sdac_write_ctrl_inst (
    .core_clk(core_clk), .rst_n(rst_n), .link_sclk(link_sclk), .frame_sel_n(frame_sel_n),
    .serial_din(serial_din), .dac_code(dac_code), .dac_mode(dac_mode), .analog_ctrl(analog_ctrl),
    .analog_output_valid(analog_output_valid), .write_done(write_done));
  sdac_host_model sdac_host_model_inst (
    .link_sclk(link_sclk), .frame_sel_n(frame_sel_n), .serial_din(serial_din));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (write_done === 1'b1) done_seen++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [6:0] ana_exp(input int m);
    case (m)
      0: ana_exp = 7'h7C;
      1: ana_exp = 7'h02;
      2: ana_exp = 7'h01;
      default: ana_exp = 7'h00;
    endcase
  endfunction
  task automatic check_state();
    check("dac_code", dac_code, exp_code);
    check("dac_mode", dac_mode, exp_mode);
    check("analog_ctrl", analog_ctrl, ana_exp(exp_mode));
  endtask
  // Power-down frames carry the stored code, so the model takes the frame's code on any complete frame
  task automatic write(input int mode, input logic [15:0] code, input int edges, input bit close);
    int d;
    d = done_seen;
    sdac_host_model_inst.send({6'h2A, mode[1:0], code}, edges, close);
    repeat (12) @(negedge core_clk);
    if (edges >= 24) begin
      exp_mode = mode;
      exp_code = code;
    end
    check("write_done count", done_seen - d, (edges >= 24) ? 1 : 0);
    check_state();
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h01fabef3;
    fail_count = 0;
    tests_run = 0;
    done_seen = 0;
    exp_code = 0;
    exp_mode = 0;
    rst_n = 1'b0;
    repeat (8) @(negedge core_clk);
    check_state();
    check("valid", analog_output_valid, 1);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    for (k = 0; k < 4; k++) begin
      val = $random(seed);
      write(0, val, 24, 1'b1);
      write(k, exp_code[15:0], 24, k[0]);
      if (k != 0) begin
        write(0, exp_code[15:0], 24, 1'b1);
        check("valid on wake", analog_output_valid, 0);
        n = 0;
        while (analog_output_valid !== 1'b1 && n < 300) begin
          @(negedge core_clk);
          n++;
        end
        check("wake span", (n >= 185 && n <= 200), 1);
      end
    end
    for (k = 0; k < 6; k++) begin
      val = $random(seed);
      n = (k == 0) ? 23 : 1 + ($unsigned($random(seed)) % 23);
      write(k % 4, val, n, 1'b1);
    end
    write(0, 16'hFFFF, 27, 1'b0);
    write(0, 16'h0000, 24, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
